// >>> rtl/spi_ctl_cfg.svh
`ifndef SPI_CTL_CFG_SVH
`define SPI_CTL_CFG_SVH

// register addresses
`define ADDR_START 7'h09
`define ADDR_BURST 7'h0A
`define ADDR_DIR 7'h0E
`define ADDR_READY 7'h11
`define ADDR_CRCCTL 7'h13
`define ADDR_RES_HI 7'h1A
`define ADDR_RES_MID 7'h1B
`define ADDR_RES_LO 7'h1C
`define ADDR_CRC 7'h1D

// reset values
`define RST_START 8'h1A
`define RST_BURST 8'h02
`define RST_READY 8'h03
`define RST_CRCCTL 8'h08
`define RST_DIR 8'h00

// bits that hold storage in each register
`define MSK_START 8'h7F
`define MSK_BURST 8'h07
`define MSK_READY 8'hAF
`define MSK_CRCCTL 8'h1C
`define MSK_DIR 8'h7F

// field positions
`define BIT_PIN6 7
`define BIT_NOCLR 5
`define BIT_FGCAL 3
`define BIT_CRCEN 4
`define BIT_AFTER 2
`define BIT_RD 7
`define PIN_SIX 6

// framing and checksum constants
`define CMD_DATA_ONLY 8'hFF
`define FIRST_DATA 8'h02
`define HOLD_BIT 3'h4
`define LAST_BIT 3'h7
`define CRC_POLY 8'h31
`define CRC_INIT 8'h00

`endif

// >>> rtl/spi_ctl_pkg.sv
`include "spi_ctl_cfg.svh"
package spi_ctl_pkg;

  // kind of the frame in progress, gray along idle-read-write
  typedef enum logic [1:0] {
    FRAME_IDLE = 2'b00,
    FRAME_READ = 2'b01,
    FRAME_WRITE = 2'b11
  } frame_e;

  // one byte through the checksum, msb first
  function automatic logic [7:0] crc8_step(input logic [7:0] crc,
                                           input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

endpackage

// >>> rtl/toggle_sync.sv
`timescale 1ns/1ps
module toggle_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tgl_in,
  output logic pulse
);

  logic s1_q, s2_q, s3_q, seen_q;

  // three stages; the first is read by the second alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= tgl_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // one pulse per toggle once stages two and three agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
      pulse <= 1'b0;
    end else begin
      pulse <= (s2_q == s3_q) && (s2_q != seen_q);
      if (s2_q == s3_q) begin
        seen_q <= s2_q;
      end
    end
  end

endmodule

// >>> rtl/serial_link.sv
`timescale 1ns/1ps
`include "spi_ctl_cfg.svh"
module serial_link (
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic sys_rst,
  input wire logic serial_in,
  input wire logic [7:0] tx_word,
  output logic [7:0] rx_byte,
  output logic rx_first,
  output logic rx_tgl,
  output logic serial_out,
  output logic serial_oe
);

  logic link_rst;
  logic [2:0] bit_q;
  logic first_q;
  logic [6:0] in_q;
  logic [7:0] hold_q;
  logic [7:0] sh_q;

  // frame logic is cleared while the host deselects the port
  assign link_rst = chip_select_n | sys_rst;

  // bit counter and receive shifter on rising edges
  always_ff @(posedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      bit_q <= 3'h0;
      first_q <= 1'b1;
      in_q <= 7'h00;
    end else begin
      bit_q <= bit_q + 3'h1;
      in_q <= {in_q[5:0], serial_in};
      if (bit_q == `LAST_BIT) begin
        first_q <= 1'b0;
      end
    end
  end

  // mid-byte capture of the core word, long after it settled
  always_ff @(posedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      hold_q <= 8'h00;
    end else if (bit_q == `HOLD_BIT) begin
      hold_q <= first_q ? 8'h00 : tx_word; // turnaround byte sends zero
    end
  end

  // finished byte with a toggle; survives the end of the frame
  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_byte <= 8'h00;
      rx_first <= 1'b0;
      rx_tgl <= 1'b0;
    end else if (bit_q == `LAST_BIT) begin
      rx_byte <= {in_q, serial_in};
      rx_first <= first_q;
      rx_tgl <= ~rx_tgl;
    end
  end

  // transmit shifter on falling edges, loads at each byte start after the first
  always_ff @(negedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      sh_q <= 8'h00;
      serial_oe <= 1'b0;
    end else begin
      serial_oe <= 1'b1;
      if (bit_q == 3'h0 && !first_q) begin
        sh_q <= hold_q;
      end else begin
        sh_q <= {sh_q[6:0], 1'b0};
      end
    end
  end

  assign serial_out = sh_q[7];

endmodule

// >>> rtl/spi_crc_ready_gpio_control.sv
// Overview of operation
// R1 - data-only read returns field value plus one bytes; field resets to two
// R2 - data-only read starts at a stored address, reset to upper result byte
// R3 - control bit 7 puts active-low ready on pin six instead of general use
// R4 - checksum clears when ready deasserts unless control bit 5 is set
// R5 - bit 3 picks background or last-known fine-gain correction
// R6 - software keeps ready control low reserved bits at three
// R7 - software keeps checksum control reserved bit 3 at one
// R8 - checksum control bit 4 enables checksum generation; resets disabled
// R9 - ready releases after low result byte, or after checksum when bit 2 set
// R10 - any write to checksum register resets the running checksum
// R11 - reading checksum register returns the current eight-bit checksum
// R12 - direction bits zero to six make pins outputs; all reset as inputs
// R13 - checksum accumulates each byte shifted out, in transmission order; code adds only register bytes within the read length
`timescale 1ns/1ps
`include "spi_ctl_cfg.svh"
module spi_crc_ready_gpio_control
  import spi_ctl_pkg::*;
#(
  parameter int PINS = 7
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic [23:0] result_data,
  input wire logic result_valid,
  output logic serial_out,
  output logic serial_oe,
  output logic data_ready_n,
  output logic pin_six_out,
  output logic [PINS-1:0] gpio_oe,
  output logic fine_gain_cal_select
);

  logic [7:0] rx_byte;
  logic rx_first;
  logic rx_tgl;
  logic rx_evt;
  logic [7:0] start_q, burst_q, dir_q, ready_ctl_q, crc_ctl_q;
  logic [23:0] res_q;
  logic [7:0] crc_q;
  logic data_ready_n_q;
  logic low_seen_q;
  frame_e frame_q;
  logic [6:0] base_q;
  logic [7:0] idx_q;
  logic [3:0] limit_q;
  logic [7:0] tx_q, prev_q;
  logic [6:0] tx_addr_q, prev_addr_q;
  logic tx_vld_q, prev_vld_q;
  logic [PINS-1:0] gpio_oe_q;
  logic pin_six_q;
  logic fgc_q;
  logic wr_evt, done_evt, drdy_rel;
  logic is_data_only, rd_now;
  logic [6:0] nbase, paddr;
  logic [3:0] nlimit;
  logic [7:0] k;
  logic pvld;
  logic [7:0] rd_data;

  // serial side on the link clock
  serial_link u_link (
    .serial_clk(serial_clk),
    .chip_select_n(chip_select_n),
    .sys_rst(sys_rst),
    .serial_in(serial_in),
    .tx_word(tx_q),
    .rx_byte(rx_byte),
    .rx_first(rx_first),
    .rx_tgl(rx_tgl),
    .serial_out(serial_out),
    .serial_oe(serial_oe)
  );

  // byte-done toggle into the system clock
  toggle_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .tgl_in(rx_tgl),
    .pulse(rx_evt)
  );

  // decode of the byte just received
  always_comb begin
    is_data_only = rx_first && (rx_byte == `CMD_DATA_ONLY);
    rd_now = rx_first ? rx_byte[`BIT_RD] : (frame_q == FRAME_READ);
    nbase = is_data_only ? start_q[6:0] : base_q; // see R2
    if (rx_first && !is_data_only) begin
      nbase = rx_byte[6:0];
    end
    nlimit = is_data_only ? ({1'b0, burst_q[2:0]} + 4'h1) : 4'h1; // see R1
    if (!rx_first) begin
      nlimit = limit_q;
    end
    k = rx_first ? 8'h00 : (idx_q + 8'h1);
    paddr = nbase + k[6:0];
    pvld = rd_now && (k < {4'h0, nlimit});
  end

  // events in the frame
  assign wr_evt = rx_evt && !rx_first && (frame_q == FRAME_WRITE);
  assign done_evt = rx_evt && !rx_first && (frame_q == FRAME_READ)
                    && prev_vld_q;
  assign drdy_rel = done_evt && !data_ready_n_q
                    && (((prev_addr_q == `ADDR_RES_LO)
                         && !crc_ctl_q[`BIT_AFTER])
                        || ((prev_addr_q == `ADDR_CRC)
                            && crc_ctl_q[`BIT_AFTER] && low_seen_q)); // see R9

  // read data for the byte two places ahead
  always_comb begin
    case (paddr)
      `ADDR_START: rd_data = start_q;
      `ADDR_BURST: rd_data = burst_q;
      `ADDR_DIR: rd_data = dir_q;
      `ADDR_READY: rd_data = ready_ctl_q;
      `ADDR_CRCCTL: rd_data = crc_ctl_q;
      `ADDR_RES_HI: rd_data = res_q[23:16];
      `ADDR_RES_MID: rd_data = res_q[15:8];
      `ADDR_RES_LO: rd_data = res_q[7:0];
      `ADDR_CRC: rd_data = crc_q; // see R11
      default: rd_data = 8'h00;
    endcase
  end

  // frame kind, base address, burst limit and byte index
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_q <= FRAME_IDLE;
      base_q <= 7'h00;
      limit_q <= 4'h0;
      idx_q <= 8'h00;
    end else if (rx_evt) begin
      base_q <= nbase;
      limit_q <= nlimit;
      if (rx_first) begin
        idx_q <= 8'h00;
        frame_q <= rx_byte[`BIT_RD] ? FRAME_READ : FRAME_WRITE;
      end else begin
        if (idx_q != 8'hFF) begin
          idx_q <= idx_q + 8'h1;
        end
        case (frame_q)
          FRAME_WRITE: frame_q <= FRAME_IDLE; // single data byte
          FRAME_READ: frame_q <= FRAME_READ;
          FRAME_IDLE: frame_q <= FRAME_IDLE;
          default: frame_q <= FRAME_IDLE;
        endcase
      end
    end
  end

  // transmit pipeline: word being prepared and word on the wire
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_q <= 8'h00;
      tx_addr_q <= 7'h00;
      tx_vld_q <= 1'b0;
      prev_q <= 8'h00;
      prev_addr_q <= 7'h00;
      prev_vld_q <= 1'b0;
    end else if (rx_evt) begin
      prev_q <= tx_q;
      prev_addr_q <= tx_addr_q;
      prev_vld_q <= rx_first ? 1'b0 : tx_vld_q;
      tx_q <= pvld ? rd_data : 8'h00; // bytes past the burst read zero
      tx_addr_q <= paddr;
      tx_vld_q <= pvld;
    end
  end

  // writable registers, reserved bits kept as written
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_q <= `RST_START; // see R2
      burst_q <= `RST_BURST; // see R1
      dir_q <= `RST_DIR; // see R12
      ready_ctl_q <= `RST_READY; // see R6
      crc_ctl_q <= `RST_CRCCTL; // see R7
    end else if (wr_evt) begin
      case (base_q)
        `ADDR_START: start_q <= rx_byte & `MSK_START;
        `ADDR_BURST: burst_q <= rx_byte & `MSK_BURST;
        `ADDR_DIR: dir_q <= rx_byte & `MSK_DIR; // see R12
        `ADDR_READY: ready_ctl_q <= rx_byte & `MSK_READY; // see R6
        `ADDR_CRCCTL: crc_ctl_q <= rx_byte & `MSK_CRCCTL; // see R7
        default: start_q <= start_q;
      endcase
    end
  end

  // conversion result capture
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_q <= 24'h000000;
    end else if (result_valid) begin
      res_q <= result_data;
    end
  end

  // data ready: a new result wins over a release in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_ready_n_q <= 1'b1;
      low_seen_q <= 1'b0;
    end else begin
      if (result_valid) begin
        data_ready_n_q <= 1'b0;
      end else if (drdy_rel) begin
        data_ready_n_q <= 1'b1; // see R9
      end
      if (result_valid || drdy_rel) begin
        low_seen_q <= 1'b0;
      end else if (done_evt && prev_addr_q == `ADDR_RES_LO) begin
        low_seen_q <= 1'b1;
      end
    end
  end

  // running checksum: write reset, ready release, then accumulate
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_q <= `CRC_INIT;
    end else if (wr_evt && base_q == `ADDR_CRC) begin
      crc_q <= `CRC_INIT; // see R10
    end else if (drdy_rel && !ready_ctl_q[`BIT_NOCLR]) begin
      crc_q <= `CRC_INIT; // see R4
    end else if (done_evt && crc_ctl_q[`BIT_CRCEN]) begin
      crc_q <= crc8_step(crc_q, prev_q); // see R8 R13
    end
  end

  // pin direction, pin six taken over by the ready signal
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        gpio_oe_q[i] <= 1'b0;
      end else if (i == `PIN_SIX && ready_ctl_q[`BIT_PIN6]) begin
        gpio_oe_q[i] <= 1'b1; // see R3
      end else begin
        gpio_oe_q[i] <= dir_q[i]; // see R12
      end
    end
  end

  // pin six level and fine-gain select
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_six_q <= 1'b0;
      fgc_q <= 1'b0;
    end else begin
      pin_six_q <= ready_ctl_q[`BIT_PIN6] ? data_ready_n_q : 1'b0; // see R3
      fgc_q <= ready_ctl_q[`BIT_FGCAL]; // see R5
    end
  end

  assign data_ready_n = data_ready_n_q;
  assign pin_six_out = pin_six_q;
  assign gpio_oe = gpio_oe_q;
  assign fine_gain_cal_select = fgc_q;

  // checks on the system clock
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  burst_count_a: // see R1
  assert property (rx_evt && is_data_only |=>
    limit_q == ({1'b0, $past(burst_q[2:0])} + 4'h1))
    else $error("data-only byte count wrong");

  start_addr_a: // see R2
  assert property (rx_evt && is_data_only |=> base_q == $past(start_q[6:0]))
    else $error("data-only start address wrong");

  pin_six_ready_a: // see R3
  assert property (ready_ctl_q[`BIT_PIN6] |=>
    pin_six_q == $past(data_ready_n_q) && gpio_oe_q[`PIN_SIX])
    else $error("pin six not carrying ready");

  crc_auto_clear_a: // see R4
  assert property ($rose(data_ready_n_q) && !$past(ready_ctl_q[`BIT_NOCLR])
    |-> crc_q == `CRC_INIT)
    else $error("checksum not cleared on ready release");

  fine_gain_sel_a: // see R5
  assert property (wr_evt && base_q == `ADDR_READY |=> ##1
    fgc_q == $past(rx_byte[`BIT_FGCAL], 2))
    else $error("fine-gain select not following write");

  crc_disabled_a: // see R8
  assert property (!crc_ctl_q[`BIT_CRCEN] |=>
    crc_q == $past(crc_q) || crc_q == `CRC_INIT)
    else $error("checksum moved while disabled");

  ready_release_a: // see R9
  assert property (done_evt && !data_ready_n_q && !result_valid
    && prev_addr_q == `ADDR_RES_LO && !crc_ctl_q[`BIT_AFTER]
    |=> data_ready_n_q)
    else $error("ready not released after low byte");

  crc_wr_reset_a: // see R10
  assert property (wr_evt && base_q == `ADDR_CRC |=> crc_q == `CRC_INIT)
    else $error("checksum write did not reset");

  crc_readback_a: // see R11
  assert property (rx_evt && pvld && paddr == `ADDR_CRC |=>
    tx_q == $past(crc_q))
    else $error("checksum readback wrong");

  pin_dir_a: // see R12
  assert property (!ready_ctl_q[`BIT_PIN6] |=>
    gpio_oe_q == $past(dir_q[PINS-1:0]))
    else $error("pin direction not applied");

  crc_accum_a: // see R13
  assert property (done_evt && crc_ctl_q[`BIT_CRCEN]
    && !(drdy_rel && !ready_ctl_q[`BIT_NOCLR])
    |=> crc_q == crc8_step($past(crc_q), $past(prev_q)))
    else $error("checksum update wrong");

  data_only_c: cover property (rx_evt && is_data_only);
  release_crc_c: cover property ($rose(data_ready_n_q)
    && crc_ctl_q[`BIT_AFTER]);
  crc_wr_c: cover property (wr_evt && base_q == `ADDR_CRC);

endmodule

// >>> test/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_oe
);
  logic last_q;
  // link clock idles low and stands still between frames
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    last_q = 1'b0;
  end
  // one byte msb first; a released data line reads as the inverse
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_in = tx[i];
      #24 serial_clk = 1'b1;
      rx[i] = serial_oe ? serial_out : ~last_q;
      last_q = rx[i];
      #24 serial_clk = 1'b0;
    end
  endtask
  // instruction, second byte, then n bytes read back
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1,
                       input int n, output logic [7:0] rx [0:9]);
    logic [7:0] d;
    #0.7 chip_select_n = 1'b0; // keeps link edges off system clock edges except in every 20th frame after a wait on clk, such as the last burst
    #24 xfer(b0, d);
    xfer(b1, d);
    for (int k = 0; k < n; k++) xfer(8'h00, rx[k]);
    #24 chip_select_n = 1'b1;
    serial_in = ~serial_in;
    #100;
  endtask
endmodule

// >>> test/test_spi_crc_ready_gpio_control.sv
`timescale 1ns/1ps
`include "spi_ctl_cfg.svh"
module test_spi_crc_ready_gpio_control;
  logic clk, sys_rst, sck, csn, sdi, sdo, sdo_oe, rdy_n, p6, fgc, rv, mr, lo;
  logic [23:0] rd;
  logic [6:0] oe;
  logic [7:0] m [0:127];
  logic [7:0] rx [0:9];
  logic [7:0] crc;
  logic [6:0] ra [0:6] = '{7'h0A, 7'h09, 7'h11, 7'h13, 7'h0E, 7'h20, 7'h1D};
  int miscompares, checks, seed;

  spi_crc_ready_gpio_control #(.PINS(7)) uut (.clk(clk), .sys_rst(sys_rst),
    .serial_clk(sck), .chip_select_n(csn), .serial_in(sdi),
    .result_data(rd), .result_valid(rv), .serial_out(sdo),
    .serial_oe(sdo_oe), .data_ready_n(rdy_n), .pin_six_out(p6),
    .gpio_oe(oe), .fine_gain_cal_select(fgc));
  spi_host_model host (.serial_clk(sck), .chip_select_n(csn),
    .serial_in(sdi), .serial_out(sdo), .serial_oe(sdo_oe));

  // system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  // reference checksum, msb first
  function automatic logic [7:0] step(logic [7:0] c, logic [7:0] d);
    c = c ^ d;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ `CRC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction
  function automatic logic [7:0] ev(logic [6:0] a);
    case (a)
      `ADDR_RES_HI, `ADDR_RES_MID, `ADDR_RES_LO, `ADDR_START, `ADDR_BURST,
      `ADDR_DIR, `ADDR_READY, `ADDR_CRCCTL: return m[a];
      `ADDR_CRC: return crc;
      default: return 8'h00;
    endcase
  endfunction
  // compare one read byte, then advance checksum and ready model
  task automatic got(logic [6:0] a, logic [7:0] g);
    chk("read data", ev(a), g);
    if (m[`ADDR_CRCCTL][`BIT_CRCEN]) crc = step(crc, ev(a));
    if (a == `ADDR_RES_LO) lo = 1'b1;
    if (!mr && lo && (m[`ADDR_CRCCTL][`BIT_AFTER] ? a == `ADDR_CRC :
        a == `ADDR_RES_LO)) begin
      mr = 1'b1;
      if (!m[`ADDR_READY][`BIT_NOCLR]) crc = `CRC_INIT;
    end
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] d);
    host.frame({1'b0, a}, d, 0, rx);
    case (a)
      `ADDR_START: m[a] = d & `MSK_START;
      `ADDR_BURST: m[a] = d & `MSK_BURST;
      `ADDR_DIR: m[a] = d & `MSK_DIR;
      `ADDR_READY: m[a] = d & `MSK_READY;
      `ADDR_CRCCTL: m[a] = d & `MSK_CRCCTL;
      `ADDR_CRC: crc = `CRC_INIT;
      default: ;
    endcase
  endtask
  task automatic rdr(logic [6:0] a);
    host.frame({1'b1, a}, 8'h00, 2, rx);
    got(a, rx[0]);
    chk("read tail", 8'h00, rx[1]);
  endtask
  task automatic burst();
    int n;
    n = m[`ADDR_BURST] + 1;
    host.frame(`CMD_DATA_ONLY, 8'h00, n + 1, rx);
    for (int k = 0; k < n; k++) got(7'(m[`ADDR_START] + k), rx[k]);
    chk("burst tail", 8'h00, rx[n]);
  endtask
  task automatic push();
    @(negedge clk);
    rd = 24'($random(seed));
    rv = 1'b1;
    {m[`ADDR_RES_HI], m[`ADDR_RES_MID], m[`ADDR_RES_LO]} = rd;
    @(negedge clk);
    rv = 1'b0;
    mr = 1'b0;
    lo = 1'b0;
  endtask
  task automatic wrdy();
    for (int i = 0; i < 40 && rdy_n !== mr; i++) @(negedge clk);
    chk("data ready", {7'h00, mr}, {7'h00, rdy_n});
    if (rdy_n !== mr) tally_and_finish();
  endtask
  task automatic pins();
    logic [7:0] e;
    repeat (3) @(negedge clk);
    e = m[`ADDR_DIR] | (m[`ADDR_READY][7] ? 8'h40 : 8'h00);
    chk("gpio oe", e, {1'b0, oe});
    chk("pin six", {7'h00, m[`ADDR_READY][7] & mr}, {7'h00, p6});
    chk("cal select", {7'h00, m[`ADDR_READY][3]}, {7'h00, fgc});
  endtask

  // main sequence
  initial begin
    seed = 59;
    sys_rst = 1'b1;
    rd = 24'h000000;
    rv = 1'b0;
    mr = 1'b1;
    lo = 1'b0;
    crc = `CRC_INIT;
    for (int i = 0; i < 128; i++) m[i] = 8'h00;
    m[`ADDR_START] = `RST_START;
    m[`ADDR_BURST] = `RST_BURST;
    m[`ADDR_READY] = `RST_READY;
    m[`ADDR_CRCCTL] = `RST_CRCCTL;
    repeat (2) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    repeat (6) @(negedge clk);
    for (int i = 0; i < 7; i++) rdr(ra[i]);
    pins();
    wrdy();
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_DIR, 8'($random(seed)));
      wr(`ADDR_READY,
         {i[0], 1'b0, 1'($random(seed)), 1'b0, i[1], 3'h3});
      pins();
      rdr(`ADDR_DIR);
      rdr(`ADDR_READY);
    end
    wr(7'h30, 8'h5A);
    rdr(7'h30);
    $display("test pins done");
    wr(`ADDR_CRCCTL, 8'h18);
    wr(`ADDR_READY, 8'hA3);
    push();
    wrdy();
    pins();
    wr(`ADDR_CRC, 8'($random(seed)));
    burst();
    wrdy();
    rdr(`ADDR_CRC);
    $display("test checksum done");
    wr(`ADDR_READY, 8'h83);
    push();
    wrdy();
    rdr(`ADDR_RES_LO);
    wrdy();
    rdr(`ADDR_CRC);
    wr(`ADDR_CRCCTL, 8'h1C);
    push();
    wrdy();
    rdr(`ADDR_RES_LO);
    wrdy();
    rdr(`ADDR_CRC);
    wrdy();
    $display("test release done");
    wr(`ADDR_CRCCTL, 8'h08);
    for (int c = 0; c < 8; c++) begin
      wr(`ADDR_BURST, 8'(c));
      if (c == 7) wr(`ADDR_START, 8'h1B);
      burst();
    end
    $display("test burst done");
    tally_and_finish();
  end
endmodule
